// ### verilog/movret_pkg.sv
// Package holding constants, opcodes, states and carrier types of the move/return executor
package movret_pkg;

   // Widths of the datapath
   localparam int DataWidth = 8;
   localparam int FileAddrWidth = 7;
   localparam int PcWidth = 13;
   localparam int OpWidth = 14;
   localparam int StackDepth = 8;
   localparam int StackPtrWidth = 3;

   // Field positions within the 14-bit instruction word
   localparam int LiteralLsb = 0;
   localparam int FileAddrLsb = 0;

   // Interrupt control register: global enable bit position
   localparam int GlobalIrqEnableBit = 7;

   // Cycle counts per instruction
   localparam logic [1:0] CyclesSingle = 2'h1;
   localparam logic [1:0] CyclesDouble = 2'h2;

   // Reset values
   localparam logic [DataWidth-1:0] AccReset = 8'h00;
   localparam logic [PcWidth-1:0] PcReset = 13'h0000;
   localparam logic [DataWidth-1:0] IntconReset = 8'h00;
   localparam logic [StackPtrWidth-1:0] SpReset = 3'h0;

   // Opcode patterns, with masks for the operand fields
   localparam logic [OpWidth-1:0] OpCopyMask = 14'h3f80;
   localparam logic [OpWidth-1:0] OpCopyVal = 14'h0080;
   localparam logic [OpWidth-1:0] OpLoadMask = 14'h3c00;
   localparam logic [OpWidth-1:0] OpLoadVal = 14'h3000;
   localparam logic [OpWidth-1:0] OpRetlMask = 14'h3c00;
   localparam logic [OpWidth-1:0] OpRetlVal = 14'h3400;
   localparam logic [OpWidth-1:0] OpRetfie = 14'h0009;
   localparam logic [OpWidth-1:0] OpNopMask = 14'h3f9f;
   localparam logic [OpWidth-1:0] OpNopVal = 14'h0000;

   // Decoded instruction kinds
   typedef enum logic [2:0] {
      InsNop,
      InsCopyAccToFile,
      InsLoadLiteralToAcc,
      InsReturnFromInterrupt,
      InsReturnWithLiteral,
      InsOther
   } ins_t;

   // Sequencer states
   typedef enum logic [0:0] {
      StExec,
      StFlush
   } state_t;

   // Write request toward the file registers
   typedef struct packed {
      logic valid;
      logic [FileAddrWidth-1:0] addr;
      logic [DataWidth-1:0] data;
   } file_wr_t;

   // Fetched instruction from the fetch path
   typedef struct packed {
      logic valid;
      logic [PcWidth-1:0] pc;
      logic [OpWidth-1:0] word;
   } fetch_t;

endpackage : movret_pkg

// ### verilog/return_stack.sv
// Hardware return stack, eight entries, with registered top-of-stack read
module return_stack (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clkEn,
   // Push and pop requests
   input wire logic push,
   input wire logic [movret_pkg::PcWidth-1:0] pushData,
   input wire logic pop,
   // Registered top entry
   output logic [movret_pkg::PcWidth-1:0] stackTopEntry
);

   // Whole state in one struct
   typedef struct packed {
      logic [movret_pkg::StackDepth-1:0][movret_pkg::PcWidth-1:0] mem;
      logic [movret_pkg::StackPtrWidth-1:0] sp;
      logic [movret_pkg::PcWidth-1:0] top;
   } stk_t;

   stk_t s_q;
   stk_t s_d;

   // Circular stack: overflow wraps silently, as a tiny core does
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.sp] = pushData;
         s_d.sp = s_q.sp + 3'h1;
         s_d.top = pushData;
      end else if (pop) begin
         s_d.sp = s_q.sp - 3'h1;
         // Top after the pop is the entry below the popped one
         s_d.top = s_q.mem[s_q.sp - 3'h2];
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign stackTopEntry = s_q.top;

endmodule : return_stack

// ### verilog/move_and_return_instructions.sv
// Executor for copy, load-literal, no-op and the two return instructions
// How it works
// - copy accumulator to addressed file, one cycle
// - literal into accumulator, flags kept, one cycle
// - interrupt return pops stack into PC, two cycles
// - interrupt return sets global enable bit seven
// - return-with-literal loads literal, flags kept
// - return-with-literal pops stack into PC, two cycles
module move_and_return_instructions (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clkEn,
   // Instruction from fetch
   input wire movret_pkg::fetch_t fetch,
   // Subroutine call push from the rest of the core
   input wire logic callPush,
   input wire logic [movret_pkg::PcWidth-1:0] callReturnPc,
   // Interrupt control register write-back from software path
   input wire logic intconWr,
   input wire logic [movret_pkg::DataWidth-1:0] intconWrData,
   // Architectural outputs
   output logic [movret_pkg::DataWidth-1:0] acc,
   output logic [movret_pkg::PcWidth-1:0] pc,
   output logic [movret_pkg::DataWidth-1:0] interruptControlReg,
   output movret_pkg::file_wr_t fileWr,
   output logic flushFetch,
   output logic handled,
   output logic busy
);

   // One struct holds every bit of state outside the stack, so reset and the clock enable
   // act on all of it at once and nothing can slip out of step
   typedef struct packed {
      movret_pkg::state_t st; // Execute or flush cycle
      logic [movret_pkg::DataWidth-1:0] acc; // Accumulator
      logic [movret_pkg::PcWidth-1:0] pc; // Program counter
      logic [movret_pkg::DataWidth-1:0] interrupt_control_reg; // Interrupt control register
      movret_pkg::file_wr_t fileWr; // File write, valid for one cycle
      logic flush; // Discard-prefetch pulse
      logic handled; // Instruction recognised pulse
      logic busy; // Second cycle of a return
      logic [1:0] cyclesLeft; // Instruction cycles still owed
   } core_t;

   // Registered state and its next value
   core_t c_q;
   core_t c_d;
   // Decoded kind of the offered word
   movret_pkg::ins_t ins;
   // Pop request toward the stack
   logic stackPop;
   // Registered top entry of the stack
   logic [movret_pkg::PcWidth-1:0] stackTop;
   // Offered word is taken at this edge
   logic accept;

   // Decode; anything else belongs to other units
   // The patterns do not overlap, so the order only sets readability
   always_comb begin
      // Unknown words fall through to other units
      ins = movret_pkg::InsOther;
      if ((fetch.word & movret_pkg::OpCopyMask) == movret_pkg::OpCopyVal) begin
         // Accumulator to a file register
         ins = movret_pkg::InsCopyAccToFile;
      end else if ((fetch.word & movret_pkg::OpLoadMask) == movret_pkg::OpLoadVal) begin
         // Bits 9:8 are don't-cares of the literal load
         ins = movret_pkg::InsLoadLiteralToAcc;
      end else if ((fetch.word & movret_pkg::OpRetlMask) == movret_pkg::OpRetlVal) begin
         // Same don't-care bits as the literal load
         ins = movret_pkg::InsReturnWithLiteral;
      end else if (fetch.word == movret_pkg::OpRetfie) begin
         // Interrupt return is one exact word
         ins = movret_pkg::InsReturnFromInterrupt;
      end else if ((fetch.word & movret_pkg::OpNopMask) == movret_pkg::OpNopVal) begin
         // Bits 6:5 are ignored by the no-op
         ins = movret_pkg::InsNop;
      end
   end

   // New instruction only taken in the execute state
   assign accept = fetch.valid && (c_q.st == movret_pkg::StExec);
   // Both returns pop; nothing else touches the stack here
   assign stackPop = accept && ((ins == movret_pkg::InsReturnFromInterrupt) ||
                                (ins == movret_pkg::InsReturnWithLiteral));

   // Return stack; pop and push never collide since returns own the cycle.
   // Its top entry is registered, so a push is visible to a return offered
   // in the very next cycle. A push offered together with a return is
   // dropped; the rest of the core never asks for both at once.
   return_stack u_stack (
      .mclk(mclk),
      .resetn(resetn),
      .clkEn(clkEn),
      .push(callPush && !stackPop),
      .pushData(callReturnPc),
      .pop(stackPop),
      .stackTopEntry(stackTop)
   );

   // Next-state logic. A return loads the counter in its first cycle and
   // spends its second in the flush state, where the word fetched behind it
   // is thrown away; the fetch path learns of this from busy and flushFetch.
   always_comb begin
      // Everything holds by default
      c_d = c_q;
      // Pulses fall unless set below, so each stands for one cycle
      c_d.fileWr.valid = 1'b0;
      c_d.flush = 1'b0;
      c_d.handled = 1'b0;
      c_d.busy = 1'b0;
      // Software write to the control register, lower priority than interrupt return on bit seven
      if (intconWr) begin
         c_d.interrupt_control_reg = intconWrData;
      end
      // Sequencer: execute a taken word, or finish a return
      unique case (c_q.st)
         movret_pkg::StExec: begin
            // Idle cycles leave everything but the pulses and a software control write alone
            if (accept) begin
               // Counter past the taken word unless a return reloads it
               c_d.pc = fetch.pc + 13'h0001;
               // Pulse only for the five instructions of this unit
               c_d.handled = (ins != movret_pkg::InsOther);
               // One cycle unless a return asks for two
               c_d.cyclesLeft = movret_pkg::CyclesSingle;
               unique case (ins)
                  movret_pkg::InsCopyAccToFile: begin
                     // Accumulator to file, no flags touched
                     c_d.fileWr.valid = 1'b1;
                     c_d.fileWr.addr = fetch.word[movret_pkg::FileAddrLsb +: 7];
                     c_d.fileWr.data = c_q.acc;
                  end
                  movret_pkg::InsLoadLiteralToAcc: begin
                     // Literal replaces the accumulator, flags kept
                     c_d.acc = fetch.word[movret_pkg::LiteralLsb +: 8];
                  end
                  movret_pkg::InsReturnFromInterrupt: begin
                     // Counter from the stack top, popped at this edge
                     c_d.pc = stackTop;
                     // Enable set after any software write, so it wins
                     c_d.interrupt_control_reg[movret_pkg::GlobalIrqEnableBit] = 1'b1;
                     // Prefetched word behind the return is stale
                     c_d.flush = 1'b1;
                     c_d.busy = 1'b1;
                     c_d.cyclesLeft = movret_pkg::CyclesDouble;
                     c_d.st = movret_pkg::StFlush;
                  end
                  movret_pkg::InsReturnWithLiteral: begin
                     // Literal and return address land together
                     c_d.acc = fetch.word[movret_pkg::LiteralLsb +: 8];
                     c_d.pc = stackTop;
                     // Prefetched word behind the return is stale
                     c_d.flush = 1'b1;
                     c_d.busy = 1'b1;
                     c_d.cyclesLeft = movret_pkg::CyclesDouble;
                     c_d.st = movret_pkg::StFlush;
                  end
                  movret_pkg::InsNop: begin
                     // Only the counter moves on
                     c_d.pc = fetch.pc + 13'h0001;
                  end
                  movret_pkg::InsOther: begin
                     // Other units own these; counter tracked anyway
                     c_d.handled = 1'b0;
                  end
                  default: begin
                     // Spare codes of the kind field
                     c_d.handled = 1'b0;
                  end
               endcase
            end
         end
         movret_pkg::StFlush: begin
            // Second cycle of a return: discard the prefetched word
            if (c_q.cyclesLeft > movret_pkg::CyclesSingle) begin
               // Count the flush cycle off the return's budget
               c_d.cyclesLeft = c_q.cyclesLeft - 2'h1;
            end else begin
               // A spent budget cannot hold the sequencer here
               c_d.cyclesLeft = movret_pkg::CyclesSingle;
            end
            // Budget spent: the next word may be taken
            if (c_d.cyclesLeft == movret_pkg::CyclesSingle) begin
               c_d.st = movret_pkg::StExec;
            end
         end
      endcase
   end

   // State register with synchronous reset and clock enable. The stack
   // shares the enable, so a frozen core never loses a pushed address
   // and a return never sees a stack that moved on without it.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         // Stack state is reset inside its own module
         c_q.st <= movret_pkg::StExec;
         c_q.acc <= movret_pkg::AccReset;
         c_q.pc <= movret_pkg::PcReset;
         c_q.interrupt_control_reg <= movret_pkg::IntconReset;
         c_q.fileWr <= '0;
         c_q.flush <= 1'b0;
         c_q.handled <= 1'b0;
         c_q.busy <= 1'b0;
         c_q.cyclesLeft <= movret_pkg::CyclesSingle;
      end else if (clkEn) begin
         c_q <= c_d;
      end
   end

   // Outputs straight from flip-flops; busy has its own bit so that no
   // decode sits between the state register and the pin
   assign acc = c_q.acc;
   assign pc = c_q.pc;
   assign interruptControlReg = c_q.interrupt_control_reg;
   assign fileWr = c_q.fileWr;
   assign flushFetch = c_q.flush;
   assign handled = c_q.handled;
   assign busy = c_q.busy;

endmodule : move_and_return_instructions

// ### bench/move_and_return_properties.sv
// Port checks for the move/return executor
module move_and_return_properties (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clkEn,
   // Instruction and side inputs
   input wire movret_pkg::fetch_t fetch,
   input wire logic callPush,
   input wire logic [12:0] callReturnPc,
   input wire logic intconWr,
   input wire logic [7:0] intconWrData,
   // Outputs under check
   input wire logic [7:0] acc,
   input wire logic [12:0] pc,
   input wire logic [7:0] interruptControlReg,
   input wire movret_pkg::file_wr_t fileWr,
   input wire logic flushFetch,
   input wire logic handled,
   input wire logic busy
);
   // Kind of word taken at this edge
   logic tk, cp, ld, rl, rf, np;
   assign tk = clkEn && fetch.valid && !busy;
   assign cp = tk && fetch.word[13:7] == 7'h01;
   assign ld = tk && fetch.word[13:10] == 4'hc;
   assign rl = tk && fetch.word[13:10] == 4'hd;
   assign rf = tk && fetch.word == 14'h0009;
   assign np = tk && (fetch.word & 14'h3f9f) == 14'h0000;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Single-cycle op: next address, handled
   sequence sPc1; handled && pc == $past(fetch.pc) + 13'h0001; endsequence
   // Return: flush the prefetch, hold off fetch
   sequence sRet; handled && busy && flushFetch; endsequence
   AST_COPY: assert property (
      cp |=> sPc1 ##0 fileWr == {1'h1, $past(fetch.word[6:0]), $past(acc)})
      else $error("copy result wrong");
   AST_LOAD: assert property (ld |=> sPc1 ##0 acc == $past(fetch.word[7:0]))
      else $error("literal load wrong");
   AST_NOP: assert property (np |=> sPc1 ##0 !fileWr.valid && $stable(acc))
      else $error("no-op changed state");
   AST_RFI: assert property (rf |=> sRet ##0 interruptControlReg[7])
      else $error("interrupt return wrong");
   AST_RETL: assert property (rl |=> sRet ##0 acc == $past(fetch.word[7:0]))
      else $error("literal return wrong");
   AST_BUSY_ONE: assert property (
      busy && clkEn |=> !busy && !handled && !fileWr.valid)
      else $error("return not two cycles");
   AST_WR_SRC: assert property (fileWr.valid && $past(clkEn) |-> $past(cp))
      else $error("stray file write");
   AST_ACC_KEEP: assert property (
      $past(resetn) && $past(clkEn) && !$past(ld || rl) |-> $stable(acc))
      else $error("accumulator changed");
endmodule : move_and_return_properties

bind move_and_return_instructions move_and_return_properties chk (.mclk, .resetn, .clkEn,
   .fetch, .callPush, .callReturnPc, .intconWr, .intconWrData, .acc, .pc,
   .interruptControlReg, .fileWr, .flushFetch, .handled, .busy);

// ### bench/testbench.sv
// Self-checking bench for the move/return executor
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
$display("wrong value at %0t: %h not %h", $time, a, b); end end
   // Inputs, all driven on the falling edge
   logic mclk = '0;
   logic resetn = '0;
   logic clkEn = 1'h1;
   logic callPush = '0;
   logic intconWr = '0;
   logic [12:0] callReturnPc = '0;
   logic [7:0] intconWrData = '0;
   movret_pkg::fetch_t fetch = '0;
   // Outputs
   logic [7:0] acc, interruptControlReg;
   logic [12:0] pc;
   movret_pkg::file_wr_t fileWr;
   logic flushFetch, handled, busy;
   // Reference state and expected results
   logic [7:0] mAcc = '0;
   logic [7:0] mIc = '0;
   logic [12:0] stk[$];
   logic [44:0] notes[$];
   logic [44:0] n;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int k;

   move_and_return_instructions uut (.mclk, .resetn, .clkEn, .fetch, .callPush,
      .callReturnPc, .intconWr, .intconWrData, .acc, .pc, .interruptControlReg, .fileWr,
      .flushFetch, .handled, .busy);

   initial forever #4 mclk = ~mclk;

   // Verdict and end of run
   task automatic test_done;
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // Offer one instruction, note its result; returns also offer a word in the busy cycle
   task automatic issue(input int op);
      logic [7:0] v;
      logic [12:0] p;
      logic [12:0] nx;
      logic [15:0] fw;
      logic [13:0] w;
      v = 8'($urandom);
      p = 13'($urandom);
      nx = p + 13'h0001;
      fw = '0;
      case (op)
         0: w = {7'h00, v[1:0], 5'h00};
         1: begin w = {7'h01, v[6:0]}; fw = {1'h1, v[6:0], mAcc}; end
         2: begin w = {4'hc, p[1:0], v}; mAcc = v; end
         3: begin w = 14'h0009; mIc[7] = 1'h1; nx = stk.pop_back(); end
         4: begin w = {4'hd, p[1:0], v}; mAcc = v; nx = stk.pop_back(); end
         // A word of another unit: counter moves, nothing is handled
         default: w = 14'h0008;
      endcase
      if (op < 5) notes.push_back({mIc, mAcc, nx, fw});
      fetch = {1'h1, p, w};
      @(negedge mclk);
      if (op > 4) `CHK({handled, pc}, {1'h0, nx})
      // Busy cycle: a copy offered here must be ignored
      if (op == 3 || op == 4) begin
         fetch.word = {7'h01, v[6:0]};
         @(negedge mclk);
      end
   endtask : issue

   // Result watcher with hang limit
   always @(negedge mclk) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         test_done();
      end
      if (handled === 1'h1) begin
         `CHK(notes.size() > 0, 1'h1)
         n = notes.pop_front();
         `CHK({interruptControlReg, acc, pc, fileWr.valid}, n[44:15])
         if (n[15]) `CHK(fileWr, n[15:0])
      end
   end

   // Main sequence: random mix, pushes and enable clears in idle cycles
   initial begin
      void'($urandom(25145));
      repeat (10) @(negedge mclk);
      resetn = 1'h1;
      for (int i = 0; i < 200; i++) begin
         // Mid-run reset: every output but flushFetch and the write address and data back to its reset value
         if (i == 100) begin
            fetch.valid = '0;
            resetn = '0;
            repeat (2) @(negedge mclk);
            `CHK({acc, pc, interruptControlReg, fileWr.valid, handled, busy}, '0)
            resetn = 1'h1;
            mAcc = '0;
            mIc = '0;
            stk.delete();
         end
         k = $urandom_range(5);
         if ($urandom_range(3) == 0 && stk.size() < 8) begin
            fetch.valid = '0;
            callPush = 1'h1;
            callReturnPc = 13'($urandom);
            stk.push_back(callReturnPc);
            @(negedge mclk);
            callPush = '0;
         end
         if ((k == 3 || k == 4) && stk.size() == 0) k = 2;
         // Clear the global enable so the return must set it
         if (k == 3) begin
            fetch.valid = '0;
            intconWr = 1'h1;
            intconWrData = 8'($urandom) & 8'h7f;
            mIc = intconWrData;
            @(negedge mclk);
            intconWr = '0;
         end
         issue(k);
         // Enable low: an offered load must wait; acc, the control register, handled and busy must hold
         if ($urandom_range(7) == 0) begin
            fetch.valid = '0;
            @(negedge mclk);
            clkEn = '0;
            fetch = {1'h1, 13'($urandom), 6'h30, 8'($urandom)};
            repeat (2) @(negedge mclk);
            `CHK({acc, interruptControlReg, handled, busy}, {mAcc, mIc, 2'h0})
            clkEn = 1'h1;
            fetch.valid = '0;
         end
      end
      fetch.valid = '0;
      repeat (4) @(negedge mclk);
      `CHK(notes.size(), 0)
      test_done();
   end
endmodule : testbench
